// *** verilog/pcsu_unit.v ***
/*
  Power condition subcommand unit: Avalon-MM slave holding the command
  block registers, executes restore, go-to and set-timer subcommands
  against a small table of power conditions.
  Assumes a single 250 MHz clock and a master that holds each request
  until waitrequest is seen low.
*/
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "pcsu_defines.vh"
module pcsu_unit (
  input wire clock,
  input wire rst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] power_cond,
  output reg [3:0] timer_run
);
  // Function states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_DONE = 3'b100;

  // Command block registers
  reg [7:0] seccnt_ff;
  reg [7:0] secnum_ff;
  reg [15:0] cyl_ff;
  reg [7:0] err_ff;
  reg [7:0] stat_ff;
  // Feature enable and static capability masks
  reg epc_en_ff;
  reg [3:0] support_ff;
  reg [3:0] change_ff;
  reg [3:0] saveable_ff;
  // Per-condition settings
  reg [15:0] cur_tmr_ff [0:3];
  reg [15:0] sav_tmr_ff [0:3];
  reg [3:0] cur_en_ff;
  reg [3:0] sav_en_ff;
  // Sequencer
  reg [2:0] state_ff;
  reg [2:0] cnt_ff;
  reg [1:0] cond_ff;
  reg [3:0] run_ff;
  reg pend_ff;
  reg [1:0] pend_id_ff;
  // Bus handshake helpers
  reg acc_ff;
  integer i;

  wire sel_restore;
  wire sel_goto;
  wire sel_timer;
  wire sel_bad;
  wire [15:0] tmr_scaled;
  wire [1:0] id = seccnt_ff[1:0];
  wire id_ok = (seccnt_ff[7:2] == 6'h00);
  wire all_sel = (seccnt_ff == `PCSU_ID_ALL);
  wire [3:0] selmask = all_sel ? 4'hF : (4'h1 << id);
  wire do_save = secnum_ff[`PCSU_BIT_SAVE];
  // Command write accepted this cycle; a forced entry still pending from the
  // previous go-to must not land after the new command has started
  wire cmd_take = avs_write && !avs_read && !acc_ff && avs_waitrequest
    && (state_ff == ST_IDLE) && (avs_address == `PCSU_ADR_CMD) && avs_byteenable[0];

  // ==========================================================
  // Helpers
  pcsu_decode u_dec (
    .code(secnum_ff[3:0]),
    .sel_restore(sel_restore),
    .sel_goto(sel_goto),
    .sel_timer(sel_timer),
    .sel_bad(sel_bad)
  );

  pcsu_timer_scale u_scale (
    .value(cyl_ff),
    .minutes(secnum_ff[`PCSU_BIT_UNITS]),
    .scaled(tmr_scaled)
  );

  // Abort test shared by state machine
  function abort_chk;
    input s_rest;
    input s_goto;
    input s_tmr;
    input s_bad;
    input en;
    input idok;
    input all;
    input [3:0] msk;
    input [3:0] sup;
    input [3:0] chg;
    input [3:0] sav;
    input save;
    begin
      abort_chk = 1'b0;
      if (s_bad)
        abort_chk = 1'b1;
      else if (!en)
        abort_chk = 1'b1;
      else if (s_rest)
        abort_chk = (!(idok | all)) | ((msk & ~(sup & chg)) != 4'h0)
          | (save & ((msk & ~sav) != 4'h0));
      else if (s_goto)
        abort_chk = all | !idok | ((msk & ~sup) != 4'h0);
      else if (s_tmr)
        abort_chk = all | !idok | ((msk & ~(sup & chg)) != 4'h0)
          | (save & ((msk & ~sav) != 4'h0));
    end
  endfunction

  wire abort_now = abort_chk(sel_restore, sel_goto, sel_timer, sel_bad, epc_en_ff,
    id_ok, all_sel, selmask, support_ff, change_ff, saveable_ff, do_save);

  // ==========================================================
  // Bus, command execution and condition tracking
  always @(posedge clock)
  begin
    if (rst)
    begin
      seccnt_ff <= 8'h00;
      secnum_ff <= 8'h00;
      cyl_ff <= 16'h0000;
      err_ff <= 8'h00;
      stat_ff <= 8'h40;
      epc_en_ff <= 1'b1;
      support_ff <= `PCSU_SUPPORT_RST;
      change_ff <= `PCSU_CHANGE_RST;
      saveable_ff <= `PCSU_SAVEABLE_RST;
      for (i = 0; i < `PCSU_NCOND; i = i + 1)
      begin
        cur_tmr_ff[i] <= `PCSU_DEF_TMR_RST;
        sav_tmr_ff[i] <= `PCSU_DEF_TMR_RST;
      end
      cur_en_ff <= 4'h0;
      sav_en_ff <= 4'h0;
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      cond_ff <= 2'h0;
      run_ff <= 4'h0;
      pend_ff <= 1'b0;
      pend_id_ff <= 2'h0;
      acc_ff <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      power_cond <= 2'h0;
      timer_run <= 4'h0;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
      acc_ff <= 1'b0;
      // Accept one access per two cycles; second cycle drops waitrequest
      if ((avs_read | avs_write) && !acc_ff && avs_waitrequest)
      begin
        acc_ff <= 1'b1;
        avs_waitrequest <= 1'b0;
        avs_readdata <= 32'h0000_0000;
        if (avs_read)
        begin
          if (avs_address == `PCSU_ADR_SECCNT)
            avs_readdata <= {24'h000000, seccnt_ff};
          else if (avs_address == `PCSU_ADR_SECNUM)
            avs_readdata <= {24'h000000, secnum_ff};
          else if (avs_address == `PCSU_ADR_CYL)
            avs_readdata <= {16'h0000, cyl_ff};
          else if (avs_address == `PCSU_ADR_ERR)
            avs_readdata <= {24'h000000, err_ff};
          else if (avs_address == `PCSU_ADR_STAT)
            avs_readdata <= {24'h000000, stat_ff};
          else if (avs_address == `PCSU_ADR_CTRL)
            // Current timer of the condition named in sector count sits on top
            avs_readdata <= {cur_tmr_ff[id], saveable_ff, change_ff, support_ff,
              3'h0, epc_en_ff};
          else if (avs_address == `PCSU_ADR_COND)
            avs_readdata <= {8'h00, sav_en_ff, cur_en_ff, 14'h0000, cond_ff};
        end
        else if (state_ff == ST_IDLE)
        begin
          // Parameter writes ignored while a command executes
          if (avs_address == `PCSU_ADR_SECCNT && avs_byteenable[0])
            seccnt_ff <= avs_writedata[7:0];
          else if (avs_address == `PCSU_ADR_SECNUM && avs_byteenable[0])
            secnum_ff <= avs_writedata[7:0];
          else if (avs_address == `PCSU_ADR_CYL)
          begin
            if (avs_byteenable[0])
              cyl_ff[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              cyl_ff[15:8] <= avs_writedata[15:8];
          end
          else if (avs_address == `PCSU_ADR_CTRL && avs_byteenable[0])
            epc_en_ff <= avs_writedata[0];
          else if (avs_address == `PCSU_ADR_CMD && avs_byteenable[0])
          begin
            // Any command write ends a forced condition, except a go-to,
            // which must see the present condition so it only moves deeper
            pend_ff <= 1'b0;
            if (cond_ff != 2'h0 && !sel_goto)
            begin
              cond_ff <= 2'h0;
            end
            run_ff <= cur_en_ff;
            stat_ff <= 8'h80;
            err_ff <= 8'h00;
            cnt_ff <= `PCSU_EXEC_CYCLES;
            state_ff <= ST_EXEC;
          end
        end
      end
      // Command sequencer: count down, then complete or abort
      case (state_ff)
        ST_IDLE:
        begin
          // Forced entry happens only after completion was posted
          if (pend_ff && !cmd_take)
          begin
            pend_ff <= 1'b0;
            if (pend_id_ff > cond_ff)
              cond_ff <= pend_id_ff;
          end
        end
        ST_EXEC:
        begin
          if (cnt_ff != 3'h0)
            cnt_ff <= cnt_ff - 3'h1;
          else
          begin
            state_ff <= ST_DONE;
            if (abort_now)
            begin
              err_ff <= 8'h00 | (8'h01 << `PCSU_ERR_ABT);
              stat_ff <= (8'h01 << `PCSU_STAT_RDY) | (8'h01 << `PCSU_STAT_ERR);
              // An aborted go-to is still a processed command
              cond_ff <= 2'h0;
            end
            else
            begin
              stat_ff <= 8'h01 << `PCSU_STAT_RDY;
              if (sel_restore)
              begin
                for (i = 0; i < `PCSU_NCOND; i = i + 1)
                begin
                  if (selmask[i])
                  begin
                    if (secnum_ff[`PCSU_BIT_DEFAULT])
                    begin
                      cur_tmr_ff[i] <= `PCSU_DEF_TMR_RST;
                      cur_en_ff[i] <= 1'b0;
                    end
                    else
                    begin
                      cur_tmr_ff[i] <= sav_tmr_ff[i];
                      cur_en_ff[i] <= sav_en_ff[i];
                    end
                    if (do_save && secnum_ff[`PCSU_BIT_DEFAULT])
                      sav_tmr_ff[i] <= `PCSU_DEF_TMR_RST;
                  end
                end
              end
              else if (sel_goto)
              begin
                run_ff <= 4'h0;
                pend_ff <= 1'b1;
                pend_id_ff <= id;
              end
              else if (sel_timer)
              begin
                cur_tmr_ff[id] <= tmr_scaled;
                cur_en_ff[id] <= secnum_ff[`PCSU_BIT_ENABLE]
                  & (cyl_ff != 16'h0000);
                if (do_save && saveable_ff[id])
                begin
                  sav_tmr_ff[id] <= tmr_scaled;
                  sav_en_ff[id] <= secnum_ff[`PCSU_BIT_ENABLE]
                    & (cyl_ff != 16'h0000);
                end
              end
            end
          end
        end
        ST_DONE:
        begin
          if (!pend_ff)
            run_ff <= cur_en_ff;
          state_ff <= ST_IDLE;
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
      // Registered outputs; timers read as halted while a condition is forced
      power_cond <= cond_ff;
      timer_run <= run_ff & ~((cond_ff != 2'h0) ? 4'hF : 4'h0);
    end
  end
endmodule

// *** verilog/pcsu_defines.vh ***
/*
  Constants of the power condition subcommand unit: register offsets,
  command block field positions, subcommand codes, condition table
  layout and reset values.
  Assumes it is included once by bare name into each design file.
*/
`ifndef PCSU_DEFINES_VH
`define PCSU_DEFINES_VH

// ==========================================================
// Register byte addresses (word aligned)
`define PCSU_ADR_SECCNT 5'h00
`define PCSU_ADR_SECNUM 5'h04
`define PCSU_ADR_CYL 5'h08
`define PCSU_ADR_CMD 5'h0C
`define PCSU_ADR_ERR 5'h10
`define PCSU_ADR_STAT 5'h14
`define PCSU_ADR_CTRL 5'h18
`define PCSU_ADR_COND 5'h1C

// ==========================================================
// Command parameter field positions
`define PCSU_BIT_DEFAULT 6
`define PCSU_BIT_UNITS 7
`define PCSU_BIT_ENABLE 5
`define PCSU_BIT_SAVE 4
`define PCSU_SUB_RESTORE 4'h0
`define PCSU_SUB_GOTO 4'h1
`define PCSU_SUB_TIMER 4'h2
`define PCSU_ID_ALL 8'hFF

// ==========================================================
// Error and status bit positions
`define PCSU_ERR_ABT 2
`define PCSU_STAT_RDY 6
`define PCSU_STAT_ERR 0

// ==========================================================
// Condition table: ids 0..3, 0 is active (shallowest)
`define PCSU_NCOND 4
`define PCSU_TMR_MAX 16'hFFFF
`define PCSU_TMR_MIN 16'h0000
`define PCSU_SUPPORT_RST 4'hE
`define PCSU_CHANGE_RST 4'hE
`define PCSU_SAVEABLE_RST 4'hE
`define PCSU_DEF_TMR_RST 16'h0064
`define PCSU_MIN_PER_100MS 16'h0258
`define PCSU_EXEC_CYCLES 3'h3

`endif

// *** verilog/pcsu_decode.v ***
/*
  Subcommand decoder: turns the low parameter nibble into one-hot
  operation selects.
  Assumes its inputs are registered command fields on the same clock.
*/
`timescale 1ns/100ps
`include "pcsu_defines.vh"
module pcsu_decode (
  input wire [3:0] code,
  output wire sel_restore,
  output wire sel_goto,
  output wire sel_timer,
  output wire sel_bad
);
  // ==========================================================
  // Nibble compare
  assign sel_restore = (code == `PCSU_SUB_RESTORE);
  assign sel_goto = (code == `PCSU_SUB_GOTO);
  assign sel_timer = (code == `PCSU_SUB_TIMER);
  assign sel_bad = ~(sel_restore | sel_goto | sel_timer);
endmodule

// *** verilog/pcsu_timer_scale.v ***
/*
  Timer value scaler: converts a 16-bit host value in minutes into
  100 ms units and clamps it to the settable range.
  Assumes purely combinational use by the main unit.
*/
`timescale 1ns/100ps
`include "pcsu_defines.vh"
module pcsu_timer_scale (
  input wire [15:0] value,
  input wire minutes,
  output reg [15:0] scaled
);
  // Wide product so large minute counts do not wrap
  reg [31:0] prod;
  // ==========================================================
  // Unit conversion and clamp
  always @*
  begin
    prod = 32'h0000_0000;
    if (minutes)
    begin
      prod = {16'h0000, value} * {16'h0000, `PCSU_MIN_PER_100MS};
    end
    else
    begin
      prod = {16'h0000, value};
    end
    if (prod > {16'h0000, `PCSU_TMR_MAX})
    begin
      scaled = `PCSU_TMR_MAX;
    end
    else if (prod[15:0] < `PCSU_TMR_MIN)
    begin
      scaled = `PCSU_TMR_MIN;
    end
    else
    begin
      scaled = prod[15:0];
    end
  end
endmodule

// *** verification/pcsu_host.sv ***
/* Host model: Avalon-MM master for the unit's command block registers.
   Assumes one clock; a request stands until waitrequest is seen low. */
`timescale 1ns/100ps
module pcsu_host (
  input wire clock,
  output reg [4:0] avs_address,
  output reg avs_read,
  output reg avs_write,
  output reg [31:0] avs_writedata,
  output reg [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  // ==========================================================
  // Idle bus at time zero
  initial
  begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end

  // One access; released data is inverted so stale values never match
  task xfer(input [4:0] a, input w, input [31:0] d, output [31:0] q);
  begin
    @(posedge clock);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  end
  endtask
endmodule

// *** verification/pcsu_unit_sva.sv ***
/* Checker for the unit's bus handshake and power condition outputs.
   Assumes it is bound to the unit and sees only its ports. */
`timescale 1ns/100ps
`include "pcsu_defines.vh"
module pcsu_unit_sva (
  input wire clock,
  input wire rst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] power_cond,
  input wire [3:0] timer_run
);
  reg [3:0] since_ff; // Cycles since a command write landed
  // ==========================================================
  // Saturating count from the last command write
  always @(posedge clock)
  begin
    if (rst)
      since_ff <= 4'hF;
    else if (avs_write && avs_address == `PCSU_ADR_CMD && !avs_waitrequest)
      since_ff <= 4'h0;
    else if (since_ff != 4'hF)
      since_ff <= since_ff + 4'h1;
  end

  property p_one;
    @(posedge clock) disable iff (rst) !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_ans;
    @(posedge clock) disable iff (rst) $rose(avs_read || avs_write) |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle after request");
  property p_cause;
    @(posedge clock) disable iff (rst) !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hold;
    @(posedge clock) disable iff (rst) !(avs_read || avs_write) |=> $stable(avs_readdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved while idle");
  property p_rst;
    @(posedge clock) disable iff (rst)
      $fell(rst) |-> power_cond == 2'b00 && timer_run == 4'h0 && avs_waitrequest;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_pc_cmd;
    @(posedge clock) disable iff (rst) $changed(power_cond) |-> since_ff <= 4'hC;
  endproperty
  a_pc_cmd: assert property (p_pc_cmd) else $error("condition moved without command");
  property p_tr_cmd;
    @(posedge clock) disable iff (rst) $changed(timer_run) |-> since_ff <= 4'hC;
  endproperty
  a_tr_cmd: assert property (p_tr_cmd) else $error("timers moved without command");
  property p_halt;
    @(posedge clock) disable iff (rst)
      $changed(power_cond) && power_cond != 2'b00 |-> timer_run == 4'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("timers run in forced condition");
endmodule

bind pcsu_unit pcsu_unit_sva u_sva (.clock(clock), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .power_cond(power_cond), .timer_run(timer_run));

// *** verification/tb.sv ***
/* Self-checking bench: random and corner subcommands through the host model.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/100ps
`include "pcsu_defines.vh"
module tb;
  reg clock;
  reg rst;
  wire [4:0] avs_address;
  wire avs_read;
  wire avs_write;
  wire [31:0] avs_writedata;
  wire [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [1:0] power_cond;
  wire [3:0] timer_run;
  integer errors;
  integer num_checks;
  integer cyc;
  integer i;
  reg [7:0] rnd; // Random state
  reg [3:0] cur_en; // Expected current enables
  reg [3:0] sav_en; // Expected saved enables
  reg [1:0] pc; // Expected condition
  reg epc; // Expected feature enable
  reg [31:0] q;
  reg [15:0] cur_t [0:3]; // Expected current timers
  reg [15:0] sav_t [0:3]; // Expected saved timers

  pcsu_unit dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .power_cond(power_cond), .timer_run(timer_run));
  pcsu_host host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Timer in 100 ms units: a minute is 600 of them, clamped to the maximum
  function [15:0] tscale(input [15:0] t, input m);
    reg [31:0] pr;
  begin
    pr = m ? {16'h0000, t} * 32'h0000_0258 : {16'h0000, t};
    tscale = (pr > 32'h0000_FFFF) ? 16'hFFFF : pr[15:0];
  end
  endfunction

  // Expected state after reset
  task model_reset;
    integer k;
  begin
    cur_en = 4'h0;
    sav_en = 4'h0;
    pc = 2'b00;
    for (k = 0; k < 4; k = k + 1)
    begin
      cur_t[k] = `PCSU_DEF_TMR_RST;
      sav_t[k] = `PCSU_DEF_TMR_RST;
    end
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %h versus %h", $time, got, exp);
      errors = errors + 1;
    end
  end
  endtask

  task rchk(input [4:0] a, input [31:0] m, input [31:0] e);
  begin
    host.xfer(a, 1'b0, 32'h0000_0000, q);
    chk(q & m, e);
  end
  endtask

  // Issue one subcommand, predict its effect, check the outcome
  task cmd(input [7:0] id, input [7:0] p, input [15:0] t);
    reg ab;
    reg [1:0] k;
  begin
    ab = !epc || id == 8'h00 || id > 8'h03 || p[3:0] > 4'h2;
    k = id[1:0];
    if (!ab && p[3:0] == 4'h2)
    begin
      cur_en[k] = p[5] && t != 16'h0000;
      cur_t[k] = tscale(t, p[7]);
      if (p[4])
      begin
        sav_en[k] = cur_en[k];
        sav_t[k] = cur_t[k];
      end
    end
    if (!ab && p[3:0] == 4'h0)
    begin
      cur_en[k] = p[6] ? 1'b0 : sav_en[k];
      cur_t[k] = p[6] ? `PCSU_DEF_TMR_RST : sav_t[k];
      if (p[4])
        sav_t[k] = cur_t[k];
    end
    if (ab || p[3:0] != 4'h1)
      pc = 2'b00;
    else if (k > pc)
      pc = k;
    host.xfer(`PCSU_ADR_SECCNT, 1'b1, {24'h00_0000, id}, q);
    host.xfer(`PCSU_ADR_SECNUM, 1'b1, {24'h00_0000, p}, q);
    host.xfer(`PCSU_ADR_CYL, 1'b1, {16'h0000, t}, q);
    host.xfer(`PCSU_ADR_CMD, 1'b1, 32'h0000_00EF, q);
    q = 32'h0000_0080;
    while (q[7])
      host.xfer(`PCSU_ADR_STAT, 1'b0, 32'h0000_0000, q);
    rchk(`PCSU_ADR_ERR, 32'h0000_00FF, {29'h0, ab, 2'b00});
    rchk(`PCSU_ADR_STAT, 32'h0000_00FF, ab ? 32'h0000_0041 : 32'h0000_0040);
    rchk(`PCSU_ADR_COND, 32'h00FF_0003, {8'h00, sav_en, cur_en, 14'h0000, pc});
    rchk(`PCSU_ADR_CTRL, 32'hFFFF_0000, {cur_t[k], 16'h0000});
    chk({28'h0, timer_run}, {28'h0, (pc != 2'b00) ? 4'h0 : cur_en});
  end
  endtask

  task stop_test;
  begin
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      errors = errors + 1;
      stop_test;
    end
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    cyc = 0;
    rnd = 8'h25;
    model_reset;
    epc = 1'b1;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rchk(`PCSU_ADR_STAT, 32'hFFFF_FFFF, 32'h0000_0040);
    rchk(`PCSU_ADR_CTRL, 32'hFFFF_FFFF, 32'h0064_EEE1);
    cmd(8'h03, 8'hB2, 16'hFFFF);
    cmd(8'h02, 8'h22, 16'h0000);
    cmd(8'h00, 8'h32, 16'h0010);
    cmd(8'h01, 8'h07, 16'h0005);
    cmd(8'h03, 8'h10, 16'h0000);
    for (i = 0; i < 14; i = i + 1)
    begin
      rnd = lfsr(rnd);
      q[7:0] = rnd[3] ? {rnd[7], 1'b0, rnd[5:4], 4'h2} : {1'b0, rnd[6], 1'b0, rnd[4], 4'h0};
      rnd = lfsr(rnd);
      cmd({6'h00, rnd[1:0]}, q[7:0], rnd[2] ? {rnd, ~rnd} : 16'h0000);
    end
    host.xfer(`PCSU_ADR_CTRL, 1'b1, 32'h0000_0000, q);
    epc = 1'b0;
    rchk(`PCSU_ADR_CTRL, 32'h0000_FFFF, 32'h0000_EEE0);
    cmd(8'h01, 8'h32, 16'h0005);
    cmd(8'h02, 8'h10, 16'h0000);
    cmd(8'h02, 8'h01, 16'h0000);
    host.xfer(`PCSU_ADR_CTRL, 1'b1, 32'h0000_0001, q);
    epc = 1'b1;
    cmd(8'h01, 8'h22, 16'h0005);
    cmd(8'h02, 8'h01, 16'h0000);
    chk({30'h0, power_cond}, 32'h0000_0002);
    chk({28'h0, timer_run}, 32'h0000_0000);
    cmd(8'h01, 8'h01, 16'h0000);
    chk({30'h0, power_cond}, 32'h0000_0002);
    cmd(8'hFF, 8'h01, 16'h0000);
    cmd(8'h04, 8'h01, 16'h0000);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    model_reset;
    @(posedge clock);
    chk({30'h0, power_cond}, 32'h0000_0000);
    rchk(`PCSU_ADR_COND, 32'hFFFF_FFFF, 32'h0000_0000);
    stop_test;
  end
endmodule
